// *** shared/ccc_defs.svh ***
// offsets, field positions, reset values and timing counts of the conversion controller
`ifndef CCC_DEFS_SVH
`define CCC_DEFS_SVH
`define CCC_CLK_PERIOD_NS 100
`define CCC_IT_MIN_NS 2800000
`define CCC_IT_MIN_CYC ((`CCC_IT_MIN_NS + `CCC_CLK_PERIOD_NS - 1) / `CCC_CLK_PERIOD_NS)
`define CCC_RST_HOLD_NS 100000000
`define CCC_RST_HOLD_CYC ((`CCC_RST_HOLD_NS + `CCC_CLK_PERIOD_NS - 1) / `CCC_CLK_PERIOD_NS)
`define CCC_ADDR_W 8
`define CCC_IT_W 24
`define CCC_RES_W 16
`define CCC_INC_W 8
`define CCC_OFS_CTRL 8'h00
`define CCC_OFS_ITIME 8'h04
`define CCC_OFS_RES_X 8'h08
`define CCC_OFS_RES_Y 8'h0C
`define CCC_OFS_RES_Z 8'h10
`define CCC_OFS_RES_NIR 8'h14
`define CCC_OFS_RES_DARK 8'h18
`define CCC_OFS_RES_CLEAR 8'h1C
`define CCC_OFS_CAL_X 8'h20
`define CCC_OFS_CAL_Y 8'h24
`define CCC_OFS_CAL_Z 8'h28
`define CCC_OFS_TEMP 8'h2C
`define CCC_OFS_STATUS 8'h30
`define CCC_CTRL_BANK_LSB 0
`define CCC_CTRL_INT_EN_BIT 2
`define CCC_CTRL_DRDY_BIT 3
`define CCC_BANK_RST 2'h2
`define CCC_BANK_ONESHOT 2'h3
`define CCC_BANK_B2ONLY 2'h1
`define CCC_RESP_OKAY 2'h0
`define CCC_RESP_SLVERR 2'h2
`endif

// *** shared/ccc_pkg.sv ***
// types shared by the conversion controller modules
package ccc_pkg;
  typedef enum logic [1:0] {CCC_IDLE, CCC_INTEG} ccc_state_t;
  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
    logic [15:0] near_infrared_channel;
    logic [15:0] dark;
    logic [15:0] clear;
  } ccc_result_t;
endpackage : ccc_pkg

// *** hw/ccc_reset_filter.sv ***
// filters the reset-low pin so only a hold longer than the limit resets the device
`timescale 1ns/1ps
`include "ccc_defs.svh"
module ccc_reset_filter #(
  parameter int HOLD_CYC = `CCC_RST_HOLD_CYC
) (
  input wire logic ref_clk, // clock
  input wire logic rst_n, // power-on reset
  input wire logic reset_low_pin, // external reset request, low active
  output logic dev_rst // device reset, high while the hold is exceeded
);
  logic [31:0] low_cnt;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt <= 32'h0000_0000;
    end else if (reset_low_pin) begin
      low_cnt <= 32'h0000_0000;
    end else if (low_cnt != 32'(HOLD_CYC)) begin
      low_cnt <= low_cnt + 32'h0000_0001;
    end
  end

  // short glitches never reach the sequencer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dev_rst <= 1'b0;
    end else begin
      dev_rst <= !reset_low_pin && (low_cnt == 32'(HOLD_CYC));
    end
  end

  hold_needed_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(dev_rst) |-> low_cnt == 32'(HOLD_CYC))
    else $error("device reset raised before the hold time");
endmodule : ccc_reset_filter

// *** hw/ccc_integrator.sv ***
// one channel converter: integrates photodiode current into a saturating count
`timescale 1ns/1ps
`include "ccc_defs.svh"
module ccc_integrator #(
  parameter int RES_W = `CCC_RES_W,
  parameter int INC_W = `CCC_INC_W
) (
  input wire logic ref_clk, // clock
  input wire logic rst_n, // asynchronous reset
  input wire logic clr, // restart integration
  input wire logic en, // integrating
  input wire logic [INC_W-1:0] inc, // photodiode current sample
  output logic [RES_W-1:0] acc // integrated count
);
  logic [RES_W:0] sum;

  assign sum = {1'b0, acc} + {{(RES_W + 1 - INC_W){1'b0}}, inc};

  // saturate instead of wrapping so a bright scene never reads dark
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= '0;
    end else if (clr) begin
      acc <= '0;
    end else if (en) begin
      acc <= sum[RES_W] ? {RES_W{1'b1}} : sum[RES_W-1:0];
    end
  end

  no_wrap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    en && !clr && sum[RES_W] |=> acc == {RES_W{1'b1}})
    else $error("channel count wrapped");
endmodule : ccc_integrator

// *** hw/ccc_conv_ctrl.sv ***
// conversion sequencer, result registers and AXI4-Lite slave of the colour sensor
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "ccc_defs.svh"
module ccc_conv_ctrl #(
  parameter int RST_HOLD_CYC = `CCC_RST_HOLD_CYC
) (
  input wire logic ref_clk, // master clock, 10 MHz
  input wire logic rst_n, // asynchronous power-on reset
  input wire logic reset_low_pin, // external reset, must be held low
  input wire logic [5:0][`CCC_INC_W-1:0] pd_current, // per channel: x y z nir dark clear
  input wire logic [15:0] temp_sample, // temperature sensor word
  input wire logic temp_valid, // temperature word is new
  output logic int_n, // interrupt line, low active
  input wire logic [`CCC_ADDR_W-1:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [`CCC_ADDR_W-1:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready // read data ready
);
  ccc_pkg::ccc_state_t state;
  ccc_pkg::ccc_result_t res;
  logic [5:0][`CCC_RES_W-1:0] acc;
  logic [5:0][`CCC_RES_W-1:0] fin;
  logic dev_rst;
  logic [1:0] bank_set;
  logic int_en;
  logic data_ready;
  logic oneshot_pend;
  logic [`CCC_IT_W-1:0] itime;
  logic [`CCC_IT_W-1:0] it_cur;
  logic [`CCC_IT_W-1:0] cnt;
  logic [1:0] mode_cur;
  logic phase;
  logic [15:0] temp;
  logic wr_go;
  logic rd_go;
  logic period_end;
  logic second;
  logic launch;
  logic start_ok;
  logic ready_ev;
  logic ctrl_rd;
  logic res_rd;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic [31:0] itime_wr;

  // sequencing and reset filtering share ref_clk; the 10 MHz oscillator is modelled by it
  ccc_reset_filter #(.HOLD_CYC(RST_HOLD_CYC)) u_rst (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .reset_low_pin(reset_low_pin),
    .dev_rst(dev_rst)
  );

  // ---------------- sequencer ----------------
  assign period_end = (state == ccc_pkg::CCC_INTEG) && ({1'b0, cnt} + 25'h000_0001 >= {1'b0, it_cur});
  // dual-bank settings need a second period on bank two
  assign second = period_end && mode_cur[1] && !phase;
  // one-shot waits for a fresh write of 3; other settings start at once
  assign start_ok = (bank_set != `CCC_BANK_ONESHOT) || oneshot_pend;
  assign launch = start_ok && ((state == ccc_pkg::CCC_IDLE) || (period_end && !second));
  // single-bank settings are ready every period, dual after bank two
  assign ready_ev = period_end && (!mode_cur[1] || phase);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ccc_pkg::CCC_IDLE;
    end else if (dev_rst) begin
      state <= ccc_pkg::CCC_IDLE;
    end else if (launch || second) begin
      state <= ccc_pkg::CCC_INTEG;
    end else if (period_end) begin
      state <= ccc_pkg::CCC_IDLE;
    end
  end

  // the setting is sampled only at launch, the start of a run's first period, never at the switch to bank two
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_cur <= 2'h0;
      phase <= 1'b0;
      it_cur <= `CCC_IT_W'(`CCC_IT_MIN_CYC);
    end else if (dev_rst) begin
      mode_cur <= 2'h0;
      phase <= 1'b0;
      it_cur <= `CCC_IT_W'(`CCC_IT_MIN_CYC);
    end else if (launch) begin
      mode_cur <= bank_set;
      phase <= (bank_set == `CCC_BANK_B2ONLY);
      it_cur <= itime;
    end else if (second) begin
      phase <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (dev_rst || launch || second) begin
      cnt <= '0;
    end else if (state == ccc_pkg::CCC_INTEG) begin
      cnt <= cnt + `CCC_IT_W'(1);
    end
  end

  // channel converters; all integrate, the bank decides which are copied out
  for (genvar ch = 0; ch < 6; ch++) begin : g_ch
    logic [`CCC_RES_W:0] fin_sum;
    ccc_integrator u_int (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .clr(launch || second || dev_rst),
      .en(state == ccc_pkg::CCC_INTEG),
      .inc(pd_current[ch]),
      .acc(acc[ch])
    );
    // the copy edge still carries a sample, which the restart would otherwise lose
    assign fin_sum = {1'b0, acc[ch]} + {{(`CCC_RES_W + 1 - `CCC_INC_W){1'b0}}, pd_current[ch]};
    assign fin[ch] = fin_sum[`CCC_RES_W] ? {`CCC_RES_W{1'b1}} : fin_sum[`CCC_RES_W-1:0];
  end

  // result registers are a second copy of the counts, so reads never see a count in progress
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      res <= '0;
    end else if (dev_rst) begin
      res <= '0;
    end else if (period_end) begin
      res.x <= fin[0];
      res.y <= fin[1];
      if (!phase) begin
        res.z <= fin[2];
        res.near_infrared_channel <= fin[3];
      end else begin
        res.dark <= fin[4];
        res.clear <= fin[5];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      temp <= 16'h0000;
    end else if (temp_valid) begin
      temp <= temp_sample;
    end
  end

  // ---------------- flags and interrupt ----------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_ready <= 1'b0;
    end else if (dev_rst) begin
      data_ready <= 1'b0;
    end else if (ready_ev) begin
      data_ready <= 1'b1;
    end else if (res_rd) begin
      data_ready <= 1'b0;
    end
  end

  // an unserviced interrupt simply stays low while newer data overwrites the results
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_n <= 1'b1;
    end else if (dev_rst) begin
      int_n <= 1'b1;
    end else if (ready_ev && int_en) begin
      int_n <= 1'b0;
    end else if (ctrl_rd) begin
      int_n <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      oneshot_pend <= 1'b0;
    end else if (dev_rst) begin
      oneshot_pend <= 1'b0;
    end else if (wr_go && awaddr == `CCC_OFS_CTRL && wstrb[0]
                 && wdata[`CCC_CTRL_BANK_LSB +: 2] == `CCC_BANK_ONESHOT) begin
      oneshot_pend <= 1'b1;
    end else if (launch) begin
      oneshot_pend <= 1'b0;
    end
  end

  // ---------------- AXI4-Lite slave ----------------
  // address and data are taken together, so the response is one cycle after both are offered
  assign wr_go = awvalid && wvalid && !bvalid;
  assign awready = wr_go;
  assign wready = wr_go;
  assign arready = !rvalid;
  assign rd_go = arvalid && arready;
  assign ctrl_rd = rd_go && araddr == `CCC_OFS_CTRL;
  assign res_rd = rd_go && araddr >= `CCC_OFS_RES_X && araddr <= `CCC_OFS_RES_CLEAR;

  always_comb begin
    itime_wr = {8'h00, itime};
    for (int b = 0; b < 4; b++) begin
      if (wstrb[b]) begin
        itime_wr[8*b +: 8] = wdata[8*b +: 8];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_set <= `CCC_BANK_RST;
      int_en <= 1'b0;
      itime <= `CCC_IT_W'(`CCC_IT_MIN_CYC);
    end else if (dev_rst) begin
      bank_set <= `CCC_BANK_RST;
      int_en <= 1'b0;
      itime <= `CCC_IT_W'(`CCC_IT_MIN_CYC);
    end else if (wr_go && awaddr == `CCC_OFS_CTRL && wstrb[0]) begin
      bank_set <= wdata[`CCC_CTRL_BANK_LSB +: 2];
      int_en <= wdata[`CCC_CTRL_INT_EN_BIT];
    end else if (wr_go && awaddr == `CCC_OFS_ITIME) begin
      // a zero period would end after one cycle anyway; it is stored as one cycle
      itime <= (itime_wr[`CCC_IT_W-1:0] == '0) ? `CCC_IT_W'(1) : itime_wr[`CCC_IT_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid <= 1'b0;
      bresp <= `CCC_RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp <= (awaddr == `CCC_OFS_CTRL || awaddr == `CCC_OFS_ITIME) ? `CCC_RESP_OKAY : `CCC_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // calibrated words are dark-corrected and only exist in the dual-bank settings
  function automatic logic [31:0] cal(input logic [15:0] v, input logic [15:0] d, input logic on);
    cal = (on && v > d) ? {16'h0000, v - d} : 32'h0000_0000;
  endfunction : cal

  always_comb begin
    next_rresp = `CCC_RESP_OKAY;
    case (araddr)
      `CCC_OFS_CTRL: next_rdata = {28'h000_0000, data_ready, int_en, bank_set};
      `CCC_OFS_ITIME: next_rdata = {8'h00, itime};
      `CCC_OFS_RES_X: next_rdata = {16'h0000, res.x};
      `CCC_OFS_RES_Y: next_rdata = {16'h0000, res.y};
      `CCC_OFS_RES_Z: next_rdata = {16'h0000, res.z};
      `CCC_OFS_RES_NIR: next_rdata = {16'h0000, res.near_infrared_channel};
      `CCC_OFS_RES_DARK: next_rdata = {16'h0000, res.dark};
      `CCC_OFS_RES_CLEAR: next_rdata = {16'h0000, res.clear};
      `CCC_OFS_CAL_X: next_rdata = cal(res.x, res.dark, bank_set[1]);
      `CCC_OFS_CAL_Y: next_rdata = cal(res.y, res.dark, bank_set[1]);
      `CCC_OFS_CAL_Z: next_rdata = cal(res.z, res.dark, bank_set[1]);
      `CCC_OFS_TEMP: next_rdata = {16'h0000, temp};
      `CCC_OFS_STATUS: next_rdata = {28'h000_0000, oneshot_pend, phase, mode_cur == 2'h3,
                                     state == ccc_pkg::CCC_INTEG};
      default: begin
        next_rdata = 32'h0000_0000;
        next_rresp = `CCC_RESP_SLVERR;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `CCC_RESP_OKAY;
    end else if (rd_go) begin
      rvalid <= 1'b1;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ---------------- checks ----------------
  sequence s_bank1_end;
    period_end && !phase;
  endsequence

  sequence s_bank2_end;
    period_end && phase;
  endsequence

  period_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n || dev_rst)
    period_end |-> cnt == it_cur - `CCC_IT_W'(1))
    else $error("integration period length wrong");
  single_ready_a: assert property (@(posedge ref_clk) disable iff (!rst_n || dev_rst)
    period_end && !mode_cur[1] |=> data_ready)
    else $error("single-bank period gave no ready");
  bank1_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n || dev_rst)
    s_bank1_end |=> $stable(res.dark) && $stable(res.clear))
    else $error("bank one touched dark or clear");
  bank2_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n || dev_rst)
    s_bank2_end |=> $stable(res.z) && $stable(res.near_infrared_channel))
    else $error("bank two touched z or nir");
  dual_ready_a: assert property (@(posedge ref_clk) disable iff (!rst_n || dev_rst)
    (mode_cur[1] and s_bank1_end) |-> !ready_ev ##1 (state == ccc_pkg::CCC_INTEG && phase && cnt == '0))
    else $error("dual-bank run skipped its second period");
  restart_now_a: assert property (@(posedge ref_clk) disable iff (!rst_n || dev_rst)
    ready_ev && bank_set != `CCC_BANK_ONESHOT |=> state == ccc_pkg::CCC_INTEG && cnt == '0)
    else $error("continuous conversion paused");
  oneshot_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_n || dev_rst)
    ready_ev && bank_set == `CCC_BANK_ONESHOT && !oneshot_pend && !wr_go |=> state == ccc_pkg::CCC_IDLE)
    else $error("one-shot ran past two periods");
  flag_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n || dev_rst)
    ready_ev |=> data_ready)
    else $error("ready flag not set");
  int_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n || dev_rst)
    ready_ev && int_en |=> !int_n)
    else $error("interrupt not asserted");
  int_release_a: assert property (@(posedge ref_clk) disable iff (!rst_n || dev_rst)
    ctrl_rd && !(ready_ev && int_en) |=> int_n)
    else $error("control read did not release interrupt");
  read_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n || dev_rst)
    res_rd && !ready_ev |=> !data_ready)
    else $error("result read left ready flag set");
  cal_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rd_go && !bank_set[1] && araddr >= `CCC_OFS_CAL_X && araddr <= `CCC_OFS_CAL_Z |=> rdata == 32'h0000_0000)
    else $error("calibrated word visible in single-bank setting");
endmodule : ccc_conv_ctrl

// *** verification/ccc_host_model.sv ***
// host controller model: an AXI4-Lite master that reaches the sensor registers
`timescale 1ns/1ps
module ccc_host_model (
  input wire logic ref_clk, // clock
  output logic [7:0] awaddr, // write address
  output logic awvalid, // write address valid
  input wire logic awready, // write address ready
  output logic [31:0] wdata, // write data
  output logic [3:0] wstrb, // write byte strobes
  output logic wvalid, // write data valid
  input wire logic wready, // write data ready
  input wire logic [1:0] bresp, // write response
  input wire logic bvalid, // write response valid
  output logic bready, // write response ready
  output logic [7:0] araddr, // read address
  output logic arvalid, // read address valid
  input wire logic arready, // read address ready
  input wire logic [31:0] rdata, // read data
  input wire logic [1:0] rresp, // read response
  input wire logic rvalid, // read data valid
  output logic rready // read data ready
);
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    wstrb = 4'hF;
  end

  // stall holds off the response ready so the slave must keep its answer standing;
  // released payloads are inverted so a stale value can never pass for a fresh one
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input int stall, output logic [1:0] r,
                    output bit ok);
    ok = 1'b0;
    r = 2'h0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (stall == 0);
    for (int n = 1; n < 300 && !ok; n++) begin
      @(posedge ref_clk);
      if (bvalid && bready) begin
        r = bresp;
        ok = 1'b1;
        bready <= 1'b0;
      end
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (n == stall && !ok) bready <= 1'b1;
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, input int stall, output logic [31:0] d, output logic [1:0] r,
                    output bit ok);
    ok = 1'b0;
    d = 32'h0;
    r = 2'h0;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (stall == 0);
    for (int n = 1; n < 300 && !ok; n++) begin
      @(posedge ref_clk);
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        ok = 1'b1;
        rready <= 1'b0;
      end
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (n == stall && !ok) rready <= 1'b1;
    end
  endtask : rd
endmodule : ccc_host_model

// *** verification/tb.sv ***
// self-checking bench of the conversion controller, driven through the host model
`timescale 1ns/1ps
`include "ccc_defs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb;
  localparam int HOLD = 20;
  localparam int IT = 8;
  logic ref_clk, rst_n, reset_low_pin, int_n, temp_valid;
  logic [5:0][7:0] pd_current;
  logic [15:0] temp_sample;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int n_fail = 0;
  int compares = 0;
  int c;
  logic [31:0] d;
  logic [1:0] r;

  ccc_conv_ctrl #(.RST_HOLD_CYC(HOLD)) ccc_conv_ctrl_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .reset_low_pin(reset_low_pin), .pd_current(pd_current), .temp_sample(temp_sample), .temp_valid(temp_valid),
    .int_n(int_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  ccc_host_model ccc_host_model_i (.ref_clk(ref_clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic test_done();
    if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er, input int stall);
    bit ok;
    ccc_host_model_i.rd(a, stall, d, r, ok);
    if (!ok) begin
      n_fail++;
      test_done();
    end
    `CHK(r, er)
    `CHK(d, e)
  endtask : rd_chk

  task automatic wr_chk(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er, input int stall);
    bit ok;
    ccc_host_model_i.wr(a, v, stall, r, ok);
    if (!ok) begin
      n_fail++;
      test_done();
    end
    `CHK(r, er)
  endtask : wr_chk

  // a wait that runs out is a hang of the sequencer, not a slow answer
  task automatic wait_int(input int lim);
    c = 0;
    while (int_n !== 1'b0 && c < lim) begin
      @(posedge ref_clk);
      c++;
    end
    if (c >= lim) begin
      n_fail++;
      test_done();
    end
  endtask : wait_int

  initial begin
    rst_n = 1'b0;
    reset_low_pin = 1'b1;
    pd_current = {8'h07, 8'h01, 8'h06, 8'h05, 8'h04, 8'h03};
    temp_sample = 16'h0000;
    temp_valid = 1'b0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_chk(`CCC_OFS_CTRL, 32'h00000002, `CCC_RESP_OKAY, 0);
    rd_chk(`CCC_OFS_ITIME, 32'h00006D60, `CCC_RESP_OKAY, 3);
    rd_chk(8'h40, 32'h00000000, `CCC_RESP_SLVERR, 0);
    wr_chk(`CCC_OFS_RES_X, 32'h00001234, `CCC_RESP_SLVERR, 2);
    @(posedge ref_clk);
    temp_sample <= 16'hA5C3;
    temp_valid <= 1'b1;
    @(posedge ref_clk);
    temp_valid <= 1'b0;
    rd_chk(`CCC_OFS_TEMP, 32'h0000A5C3, `CCC_RESP_OKAY, 0);
    // the period and bank picked here only apply once the reset-time dual-bank run ends
    wr_chk(`CCC_OFS_ITIME, 32'(IT), `CCC_RESP_OKAY, 0);
    wr_chk(`CCC_OFS_CTRL, 32'h00000004, `CCC_RESP_OKAY, 0);
    wait_int(60000);
    `CHK(c > 50000, 1'b1)
    repeat (IT + 2) @(posedge ref_clk);
    rd_chk(`CCC_OFS_CTRL, 32'h0000000C, `CCC_RESP_OKAY, 0);
    wait_int(IT + 3);
    rd_chk(`CCC_OFS_RES_X, 32'(IT * 3), `CCC_RESP_OKAY, 2);
    rd_chk(`CCC_OFS_RES_Z, 32'(IT * 5), `CCC_RESP_OKAY, 0);
    rd_chk(`CCC_OFS_RES_NIR, 32'(IT * 6), `CCC_RESP_OKAY, 0);
    rd_chk(`CCC_OFS_RES_DARK, 32'h00006D60, `CCC_RESP_OKAY, 0);
    rd_chk(`CCC_OFS_RES_CLEAR, 32'h0000FFFF, `CCC_RESP_OKAY, 0);
    rd_chk(`CCC_OFS_CAL_X, 32'h00000000, `CCC_RESP_OKAY, 0);
    wr_chk(`CCC_OFS_CTRL, 32'h00000005, `CCC_RESP_OKAY, 0);
    repeat (IT + 2) @(posedge ref_clk);
    pd_current[3] <= 8'h0B;
    pd_current[5] <= 8'h0C;
    repeat (2 * IT + 2) @(posedge ref_clk);
    rd_chk(`CCC_OFS_RES_NIR, 32'(IT * 6), `CCC_RESP_OKAY, 0);
    rd_chk(`CCC_OFS_RES_CLEAR, 32'(IT * 12), `CCC_RESP_OKAY, 0);
    rd_chk(`CCC_OFS_RES_DARK, 32'(IT * 1), `CCC_RESP_OKAY, 0);
    wr_chk(`CCC_OFS_CTRL, 32'h00000007, `CCC_RESP_OKAY, 1);
    repeat (3 * IT + 6) @(posedge ref_clk);
    rd_chk(`CCC_OFS_CTRL, 32'h0000000F, `CCC_RESP_OKAY, 0);
    @(posedge ref_clk);
    `CHK(int_n, 1'b1)
    rd_chk(`CCC_OFS_RES_NIR, 32'(IT * 11), `CCC_RESP_OKAY, 0);
    rd_chk(`CCC_OFS_RES_Y, 32'(IT * 4), `CCC_RESP_OKAY, 0);
    rd_chk(`CCC_OFS_CAL_X, 32'(IT * 2), `CCC_RESP_OKAY, 0);
    rd_chk(`CCC_OFS_CTRL, 32'h00000007, `CCC_RESP_OKAY, 0);
    pd_current[0] <= 8'h09;
    repeat (3 * IT) @(posedge ref_clk);
    rd_chk(`CCC_OFS_RES_X, 32'(IT * 3), `CCC_RESP_OKAY, 0);
    `CHK(int_n, 1'b1)
    rd_chk(`CCC_OFS_STATUS, 32'h00000006, `CCC_RESP_OKAY, 0);
    wr_chk(`CCC_OFS_CTRL, 32'h00000007, `CCC_RESP_OKAY, 0);
    wait_int(100);
    `CHK(c >= 2 * IT - 2 && c <= 2 * IT + 3, 1'b1)
    rd_chk(`CCC_OFS_RES_X, 32'(IT * 9), `CCC_RESP_OKAY, 0);
    // a low pulse shorter than the hold must leave everything untouched
    reset_low_pin <= 1'b0;
    repeat (HOLD - 5) @(posedge ref_clk);
    reset_low_pin <= 1'b1;
    `CHK(int_n, 1'b0)
    rd_chk(`CCC_OFS_ITIME, 32'(IT), `CCC_RESP_OKAY, 0);
    reset_low_pin <= 1'b0;
    repeat (HOLD + 5) @(posedge ref_clk);
    reset_low_pin <= 1'b1;
    `CHK(int_n, 1'b1)
    rd_chk(`CCC_OFS_CTRL, 32'h00000002, `CCC_RESP_OKAY, 0);
    rd_chk(`CCC_OFS_ITIME, 32'h00006D60, `CCC_RESP_OKAY, 0);
    test_done();
  end
endmodule : tb
